// ==== verilog/srw_top.sv ====
// Purpose: supply reset stretcher and watchdog with AXI4-Lite status
// Assumes: all pins synchronous to aclk; analog detection done outside
// Notes:
// Notes on behaviour
// [RULE1] reset low while supply invalid
// [RULE2] stretch reset 50 ms or 200 ms
// [RULE3] active-high reset is inverse of reset_n
// [RULE4] missed kick within timeout issues reset pulse
// [RULE5] long timeout right after any reset
// [RULE6] watchdog count restarts when reset ends
// [RULE7] first kick after reset selects normal timeout
// [RULE8] every kick edge restarts the count
// [RULE9] stuck kick gives pulse per long timeout
// [RULE10] floating kick disables the watchdog
// [RULE11] external clock: 1024/4096 timeout, 512/2048 pulse
// [RULE12] internal oscillator: 1.6 s or 100 ms
// [RULE13] internal timebase nominally 10.24 kHz
// [RULE14] fixed variant: 1.6 s timeout only
// [RULE15] timeout flag low until next kick edge
// [RULE16] timeout flag high while supply low
// [RULE17] processor kicks at least every 70 ms
// [RULE18] watchdog pulse equals power-up pulse width
// [RULE19] supply-low output follows supply validity
// [RULE20] battery mode ignores pins, flag high
`timescale 1ns/1ns
`default_nettype none
`include "srw_consts.svh"

module srw_top
#(
	parameter int OSC_DIV = `SRW_CLK_HZ / `SRW_OSC_HZ,
	parameter int LONG_TICKS = (`SRW_T_LONG_MS * `SRW_OSC_HZ) / `SRW_MS_PER_S,
	parameter int CNT_W = 15
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic supply_valid,
	input wire logic battery_backup,
	input wire logic watchdog_kick_input,
	input wire logic kick_floating,
	input wire logic timebase_select,
	input wire logic timebase_input,
	output logic reset_n,
	output logic reset_out,
	output logic watchdog_timeout_flag,
	output logic supply_low_n
);
	import srw_pkg::*;

	localparam logic [CNT_W-1:0] LIM_LONG = CNT_W'(LONG_TICKS);
	localparam logic [CNT_W-1:0] LIM_SHORT =
		CNT_W'((`SRW_T_SHORT_MS * `SRW_OSC_HZ) / `SRW_MS_PER_S);
	localparam logic [CNT_W-1:0] LIM_PULSE =
		CNT_W'((`SRW_T_PULSE_MS * `SRW_OSC_HZ) / `SRW_MS_PER_S);
	localparam logic [CNT_W-1:0] LIM_PULSE_LONG =
		CNT_W'((`SRW_T_PULSE_LONG_MS * `SRW_OSC_HZ) / `SRW_MS_PER_S);
	localparam logic [CNT_W-1:0] LIM_EXT_NORMAL = CNT_W'(`SRW_EXT_NORMAL_CLKS);
	localparam logic [CNT_W-1:0] LIM_EXT_AFTER = CNT_W'(`SRW_EXT_AFTER_RST_CLKS);
	localparam logic [CNT_W-1:0] LIM_EXT_PULSE = CNT_W'(`SRW_EXT_PULSE_CLKS);
	localparam logic [CNT_W-1:0] LIM_EXT_PULSE_LONG = CNT_W'(`SRW_EXT_PULSE_LONG_CLKS);

	srw_state_t state;
	srw_state_t next_state;
	srw_ctrl_t ctrl;
	srw_ctrl_t next_ctrl;
	srw_status_t status;
	logic [CNT_W-1:0] rst_cnt;
	logic [CNT_W-1:0] next_rst_cnt;
	logic [CNT_W-1:0] wd_cnt;
	logic [CNT_W-1:0] next_wd_cnt;
	logic long_mode;
	logic next_long_mode;
	logic next_flag;
	logic kick_prev;
	logic kick_edge;
	logic supply_ok;
	logic ext_mode;
	logic tick;
	logic [CNT_W-1:0] wd_lim;
	logic [CNT_W-1:0] pulse_lim;

	logic aw_held;
	logic next_aw_held;
	logic [7:0] aw_addr;
	logic [7:0] next_aw_addr;
	logic w_held;
	logic next_w_held;
	logic [31:0] w_data;
	logic [31:0] next_w_data;
	logic w_lane0;
	logic next_w_lane0;
	logic next_awready;
	logic next_wready;
	logic next_bvalid;
	logic [1:0] next_bresp;
	logic next_arready;
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;

	// battery mode counts as invalid supply and ignores the pins
	assign supply_ok = supply_valid && !battery_backup; // see [RULE20]
	assign ext_mode = !timebase_select && !ctrl.fixed_timing; // see [RULE12]
	assign kick_edge = (watchdog_kick_input != kick_prev) && !kick_floating
		&& !battery_backup; // see [RULE8]

	srw_tick #(.DIV(OSC_DIV)) u_tick
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.ext_sel(ext_mode),
		.ext_clk(timebase_input),
		.tick(tick)
	);

	always_comb
	begin
		if (ctrl.fixed_timing)
		begin
			wd_lim = LIM_LONG; // see [RULE14]
		end
		else if (ext_mode)
		begin
			wd_lim = long_mode ? LIM_EXT_AFTER : LIM_EXT_NORMAL; // see [RULE11]
		end
		else if (long_mode || timebase_input)
		begin
			wd_lim = LIM_LONG; // see [RULE5]
		end
		else
		begin
			wd_lim = LIM_SHORT; // see [RULE12]
		end
		// same width for supply and watchdog pulses
		if (ext_mode)
		begin
			pulse_lim = ctrl.long_pulse ? LIM_EXT_PULSE_LONG : LIM_EXT_PULSE; // see [RULE18]
		end
		else
		begin
			pulse_lim = ctrl.long_pulse ? LIM_PULSE_LONG : LIM_PULSE; // see [RULE2]
		end
	end

	always_comb
	begin
		next_state = state;
		next_rst_cnt = rst_cnt;
		next_wd_cnt = wd_cnt;
		next_long_mode = long_mode;
		next_flag = watchdog_timeout_flag;
		if (!supply_ok)
		begin
			next_state = ST_LOW; // see [RULE1]
			next_rst_cnt = '0;
			next_wd_cnt = '0;
			next_long_mode = 1'b1;
			next_flag = 1'b1; // see [RULE16]
		end
		else
		begin
			case (state)
				ST_LOW:
				begin
					next_state = ST_PULSE;
					next_rst_cnt = '0;
				end
				ST_PULSE:
				begin
					if (kick_edge)
					begin
						next_flag = 1'b1; // see [RULE15]
					end
					if (tick)
					begin
						if (rst_cnt >= pulse_lim - 1'b1)
						begin
							next_state = ST_WATCH;
							next_wd_cnt = '0; // see [RULE6]
						end
						else
						begin
							next_rst_cnt = rst_cnt + 1'b1;
						end
					end
				end
				ST_WATCH:
				begin
					if (kick_floating)
					begin
						next_wd_cnt = '0; // see [RULE10]
					end
					else if (kick_edge)
					begin
						next_wd_cnt = '0; // see [RULE8]
						next_long_mode = 1'b0; // see [RULE7]
						next_flag = 1'b1; // see [RULE15]
					end
					else if (tick)
					begin
						if (wd_cnt >= wd_lim - 1'b1)
						begin
							next_state = ST_PULSE; // see [RULE4] [RULE9]
							next_rst_cnt = '0;
							next_long_mode = 1'b1; // see [RULE5]
							next_flag = 1'b0; // see [RULE15]
						end
						else
						begin
							next_wd_cnt = wd_cnt + 1'b1;
						end
					end
				end
				default:
				begin
					next_state = ST_LOW;
				end
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= ST_LOW;
			rst_cnt <= '0;
			wd_cnt <= '0;
			long_mode <= 1'b1;
			kick_prev <= 1'b0;
			watchdog_timeout_flag <= 1'b1;
			reset_n <= 1'b0;
			reset_out <= 1'b1;
			supply_low_n <= 1'b0;
		end
		else
		begin
			state <= next_state;
			rst_cnt <= next_rst_cnt;
			wd_cnt <= next_wd_cnt;
			long_mode <= next_long_mode;
			kick_prev <= watchdog_kick_input;
			watchdog_timeout_flag <= next_flag;
			reset_n <= (next_state == ST_WATCH); // see [RULE1] [RULE2]
			reset_out <= (next_state != ST_WATCH); // see [RULE3]
			supply_low_n <= supply_ok; // see [RULE19]
		end
	end

	assign status.ext_timebase = ext_mode;
	assign status.supply_low = !supply_ok;
	assign status.long_timeout = long_mode;
	assign status.timeout_flag = watchdog_timeout_flag;
	assign status.reset_active = !reset_n;

	always_comb
	begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held = w_held;
		next_w_data = w_data;
		next_w_lane0 = w_lane0;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_ctrl = ctrl;
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_lane0 = s_axi_wstrb[0];
		end
		if (s_axi_bvalid && s_axi_bready)
		begin
			next_bvalid = 1'b0;
		end
		if (next_aw_held && next_w_held && !next_bvalid)
		begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			if (next_aw_addr == `SRW_ADDR_CTRL)
			begin
				next_bresp = `SRW_RESP_OKAY;
				if (next_w_lane0)
				begin
					next_ctrl.fixed_timing = next_w_data[`SRW_CTRL_FIXED_BIT];
					next_ctrl.long_pulse = next_w_data[`SRW_CTRL_LONG_PULSE_BIT];
				end
			end
			else if (next_aw_addr == `SRW_ADDR_STATUS || next_aw_addr == `SRW_ADDR_COUNT)
			begin
				next_bresp = `SRW_RESP_OKAY;
			end
			else
			begin
				next_bresp = `SRW_RESP_SLVERR;
			end
		end
		next_awready = !next_aw_held && !next_bvalid;
		next_wready = !next_w_held && !next_bvalid;
	end

	always_comb
	begin
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_rvalid && s_axi_rready)
		begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_rvalid = 1'b1;
			next_rresp = `SRW_RESP_OKAY;
			if (s_axi_araddr == `SRW_ADDR_CTRL)
			begin
				next_rdata = {30'h0, ctrl};
			end
			else if (s_axi_araddr == `SRW_ADDR_STATUS)
			begin
				next_rdata = {27'h0, status};
			end
			else if (s_axi_araddr == `SRW_ADDR_COUNT)
			begin
				next_rdata = {{(32-CNT_W){1'b0}}, wd_cnt};
			end
			else
			begin
				next_rdata = 32'h0;
				next_rresp = `SRW_RESP_SLVERR;
			end
		end
		next_arready = !next_rvalid;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			aw_addr <= 8'h0;
			w_held <= 1'b0;
			w_data <= 32'h0;
			w_lane0 <= 1'b0;
			ctrl <= `SRW_CTRL_RESET;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SRW_RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `SRW_RESP_OKAY;
		end
		else
		begin
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held <= next_w_held;
			w_data <= next_w_data;
			w_lane0 <= next_w_lane0;
			ctrl <= next_ctrl;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

endmodule

`default_nettype wire

// ==== verilog/srw_consts.svh ====
// Purpose: shared constants for the supply reset and watchdog block
// Assumes: 100 MHz aclk, nominal 10.24 kHz internal timebase
// Notes: times in their own unit, counts derived where used
`ifndef SRW_CONSTS_SVH
`define SRW_CONSTS_SVH

`define SRW_CLK_HZ 100000000
`define SRW_OSC_HZ 10240
`define SRW_MS_PER_S 1000

`define SRW_T_LONG_MS 1600
`define SRW_T_SHORT_MS 100
`define SRW_T_PULSE_MS 50
`define SRW_T_PULSE_LONG_MS 200

`define SRW_EXT_NORMAL_CLKS 1024
`define SRW_EXT_AFTER_RST_CLKS 4096
`define SRW_EXT_PULSE_CLKS 512
`define SRW_EXT_PULSE_LONG_CLKS 2048

`define SRW_ADDR_CTRL 8'h00
`define SRW_ADDR_STATUS 8'h04
`define SRW_ADDR_COUNT 8'h08

`define SRW_CTRL_FIXED_BIT 1
`define SRW_CTRL_LONG_PULSE_BIT 0
`define SRW_CTRL_RESET 2'h0

`define SRW_RESP_OKAY 2'h0
`define SRW_RESP_SLVERR 2'h2

`endif

// ==== verilog/srw_pkg.sv ====
// Purpose: types for the supply reset and watchdog block
// Assumes: nothing beyond the constants header
// Notes: state codes are written out
package srw_pkg;

	typedef enum logic [1:0]
	{
		ST_LOW = 2'b00,
		ST_PULSE = 2'b01,
		ST_WATCH = 2'b10
	} srw_state_t;

	typedef struct packed
	{
		logic fixed_timing;
		logic long_pulse;
	} srw_ctrl_t;

	typedef struct packed
	{
		logic ext_timebase;
		logic supply_low;
		logic long_timeout;
		logic timeout_flag;
		logic reset_active;
	} srw_status_t;

endpackage

// ==== verilog/srw_tick.sv ====
// Purpose: timebase tick, internal divider or external clock edges
// Assumes: timebase input already synchronous to aclk
// Notes: tick is a one-cycle registered pulse
`timescale 1ns/1ns
`default_nettype none
`include "srw_consts.svh"

module srw_tick
#(
	parameter int DIV = `SRW_CLK_HZ / `SRW_OSC_HZ,
	parameter int DIV_W = 14
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ext_sel,
	input wire logic ext_clk,
	output logic tick
);
	import srw_pkg::*;

	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV - 1);

	logic [DIV_W-1:0] div_cnt;
	logic [DIV_W-1:0] next_div_cnt;
	logic ext_prev;
	logic next_tick;

	always_comb
	begin
		next_div_cnt = div_cnt;
		next_tick = 1'b0;
		if (ext_sel)
		begin
			next_div_cnt = '0;
			next_tick = ext_clk && !ext_prev; // see [RULE11]
		end
		else if (div_cnt == DIV_LAST)
		begin
			next_div_cnt = '0;
			next_tick = 1'b1; // see [RULE13]
		end
		else
		begin
			next_div_cnt = div_cnt + 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			div_cnt <= '0;
			ext_prev <= 1'b0;
			tick <= 1'b0;
		end
		else
		begin
			div_cnt <= next_div_cnt;
			ext_prev <= ext_clk;
			tick <= next_tick;
		end
	end

endmodule

`default_nettype wire

// ==== test/srw_top_sva.sv ====
// Purpose: port checker for srw_top
// Assumes: one aclk domain
// Notes: bound at the foot
`timescale 1ns/1ns
`default_nettype none
module srw_top_sva
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic supply_valid,
	input wire logic battery_backup,
	input wire logic kick_floating,
	input wire logic reset_n,
	input wire logic reset_out,
	input wire logic watchdog_timeout_flag,
	input wire logic supply_low_n
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_supply_up;
		$rose(supply_valid) && !battery_backup;
	endsequence
	sequence s_held_low;
		!reset_n [*8];
	endsequence
	a_reset_inverse: assert property (reset_out == !reset_n)
		else $error("active-high reset not inverse");
	a_supply_reset: assert property (!supply_valid |=> !reset_n)
		else $error("reset high with supply invalid");
	a_stretch_min: assert property (s_supply_up |=> s_held_low)
		else $error("reset released too early");
	a_flag_forced_high: assert property (!supply_valid |=> watchdog_timeout_flag)
		else $error("flag low with supply invalid");
	a_low_line_ok: assert property (supply_valid && !battery_backup |=> supply_low_n)
		else $error("supply low output stuck low");
	a_battery_state: assert property (battery_backup |=>
		!reset_n && watchdog_timeout_flag && !supply_low_n)
		else $error("battery mode outputs wrong");
	a_flag_fall_reset: assert property ($fell(watchdog_timeout_flag) |-> ##[0:2] !reset_n)
		else $error("timeout without reset pulse");
	a_float_quiet: assert property (kick_floating && $past(kick_floating) |->
		!$fell(watchdog_timeout_flag))
		else $error("timeout while kick floating");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read not answered");
endmodule
bind srw_top srw_top_sva i_srw_top_sva (.aclk(aclk), .aresetn(aresetn),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.supply_valid(supply_valid), .battery_backup(battery_backup), .kick_floating(kick_floating),
	.reset_n(reset_n), .reset_out(reset_out), .watchdog_timeout_flag(watchdog_timeout_flag),
	.supply_low_n(supply_low_n));
`default_nettype wire

// ==== test/srw_cpu_model.sv ====
// Purpose: processor side that kicks the watchdog
// Assumes: period in aclk cycles, 0 stops kicking
// Notes: kick line frozen while reset is low
`timescale 1ns/1ns
`default_nettype none
module srw_cpu_model
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic reset_n,
	input wire logic [15:0] period,
	output logic kick
);
	logic [15:0] cnt;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			kick <= 1'b0;
			cnt <= 16'h0;
		end
		else if (!reset_n || period == 16'h0)
			cnt <= 16'h0;
		else if (cnt == period - 16'h1)
		begin
			kick <= ~kick;
			cnt <= 16'h0;
		end
		else
			cnt <= cnt + 16'h1;
	end
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Purpose: bench for srw_top
// Assumes: timebase ticks every 2 aclk cycles
// Notes: periods judged in aclk cycles
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
	$display("[FAIL] %0t got %0h want %0h", $time, a, b); end end
module tb_top;
	logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
	logic sv = 1, bat = 0, flt = 0, tsel = 0, tin = 0, tgl = 1;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, data;
	logic [15:0] period = 16'h0;
	logic [1:0] resp;
	wire awr, wr, bv, arr, rv, rst_n, rst, flag, low_n, kick;
	wire [1:0] br, rr;
	wire [31:0] rd;
	int miscompares = 0, total_checks = 0, n;
	srw_top #(.OSC_DIV(2), .LONG_TICKS(2048)) i_srw_top (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .supply_valid(sv),
		.battery_backup(bat), .watchdog_kick_input(kick), .kick_floating(flt),
		.timebase_select(tsel), .timebase_input(tin), .reset_n(rst_n), .reset_out(rst),
		.watchdog_timeout_flag(flag), .supply_low_n(low_n));
	srw_cpu_model i_srw_cpu_model (.aclk(aclk), .aresetn(aresetn), .reset_n(rst_n),
		.period(period), .kick(kick));
	initial forever #5 aclk = ~aclk;
	always @(posedge aclk) tin <= tgl ? ~tin : 1'b0;
	task wt(input logic lvl, input int lim);
		n = 0;
		while (rst_n !== lvl && n < lim)
		begin
			@(negedge aclk);
			n++;
		end
	endtask
	function logic near(int e);
		return n >= e - 8 && n <= e + 8;
	endfunction
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge aclk);
		awa <= a;
		ara <= a;
		wd <= d;
		awv <= w;
		wv <= w;
		bre <= w;
		arv <= !w;
		rre <= !w;
		do
		begin
			@(negedge aclk);
			ta = w ? awv && awr : arv && arr;
			tw = wv && wr;
			tb = w ? bv : rv;
			resp = w ? br : rr;
			data = rd;
			@(posedge aclk);
			if (ta && w) awv <= 0;
			if (ta && !w) arv <= 0;
			if (tw) wv <= 0;
		end
		while (!tb);
		bre <= 0;
		rre <= 0;
	endtask
	task supply_cycle;
		@(posedge aclk);
		sv <= 0;
		repeat (3) @(negedge aclk);
		`CHK(rst_n, 1'b0)
		`CHK(low_n, 1'b0)
		@(posedge aclk);
		sv <= 1;
	endtask
	task t_power;
		wt(1, 3000);
		`CHK(near(1024), 1'b1)
		`CHK(rst, 1'b0)
		`CHK(low_n, 1'b1)
		$display("t_power done");
	endtask
	task t_regs;
		bus(0, 8'h00, 0);
		`CHK(data, 32'h0)
		bus(0, 8'h04, 0);
		`CHK(data[4:0], 5'h16)
		bus(1, 8'h00, 32'h1);
		`CHK(resp, 2'h0)
		bus(0, 8'h00, 0);
		`CHK(data, 32'h1)
		bus(0, 8'h0c, 0);
		`CHK(resp, 2'h2)
		$display("t_regs done");
	endtask
	task t_long;
		supply_cycle;
		wt(1, 6000);
		`CHK(near(4096), 1'b1)
		bus(1, 8'h00, 32'h0);
		$display("t_long done");
	endtask
	task t_timeout;
		repeat (2)
		begin
			wt(0, 10000);
			`CHK(near(8192), 1'b1)
			`CHK(rst, 1'b1)
			wt(1, 3000);
			`CHK(near(1024), 1'b1)
			`CHK(flag, 1'b0)
		end
		$display("t_timeout done");
	endtask
	task t_short;
		@(posedge aclk);
		period <= 16'd1500;
		wt(0, 9000);
		`CHK(n, 9000)
		`CHK(flag, 1'b1)
		@(kick);
		period <= 16'h0;
		wt(0, 4000);
		`CHK(near(2048), 1'b1)
		wt(1, 3000);
		$display("t_short done");
	endtask
	task t_supply;
		supply_cycle;
		`CHK(flag, 1'b1)
		bat <= 1;
		repeat (3) @(negedge aclk);
		`CHK(rst_n, 1'b0)
		`CHK(low_n, 1'b0)
		@(posedge aclk);
		bat <= 0;
		wt(1, 3000);
		`CHK(near(1024), 1'b1)
		$display("t_supply done");
	endtask
	task t_float;
		@(posedge aclk);
		flt <= 1;
		wt(0, 10000);
		`CHK(n, 10000)
		@(posedge aclk);
		flt <= 0;
		$display("t_float done");
	endtask
	task t_internal;
		@(posedge aclk);
		tgl <= 0;
		tsel <= 1;
		supply_cycle;
		wt(1, 3000);
		`CHK(near(1024), 1'b1)
		wt(0, 6000);
		`CHK(near(4096), 1'b1)
		wt(1, 3000);
		period <= 16'd200;
		@(kick);
		period <= 16'h0;
		wt(0, 4000);
		`CHK(near(2048), 1'b1)
		bus(1, 8'h00, 32'h2);
		supply_cycle;
		wt(1, 3000);
		period <= 16'd200;
		@(kick);
		period <= 16'h0;
		wt(0, 6000);
		`CHK(near(4096), 1'b1)
		$display("t_internal done");
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		t_power;
		t_regs;
		t_long;
		t_timeout;
		t_short;
		t_supply;
		t_float;
		t_internal;
		test_done;
	end
	initial
	begin
		#900000;
		miscompares++;
		test_done;
	end
endmodule
`default_nettype wire
